// File: logic/pmw_pkg.sv
// package: constants and types of the power mode and wake controller
package pmw_pkg;
    localparam int          NUM_MON          = 5;
    localparam int          NUM_GPIO         = 4;
    localparam int          RET_WIDTH        = 64;
    localparam int          TIMER_WIDTH      = 16;
    // wake flag bit positions
    localparam int          FLAG_LIN         = 0;
    localparam int          FLAG_CYC         = 1;
    localparam int          FLAG_SENSE       = 2;
    localparam int          NUM_FLAG_FIXED   = 3;
    localparam int          NUM_FLAGS        = NUM_FLAG_FIXED + NUM_MON + NUM_GPIO;
    // edge select encoding
    localparam logic [1:0]  EDGE_RISE        = 2'h1;
    localparam logic [1:0]  EDGE_FALL        = 2'h2;
    localparam logic [1:0]  EDGE_BOTH        = 2'h3;
    // reset values
    localparam logic        RST_LIN_WAKE_EN  = 1'h0;
    localparam logic        RST_MON_WAKE_EN  = 1'h1;
    localparam logic        RST_CYC_WAKE_EN  = 1'h1;
    // timing
    localparam int          CLK_MHZ          = 250;
    localparam int          ENTRY_NS         = 40;
    localparam int          ENTRY_CYCLES     = (ENTRY_NS * CLK_MHZ + 999) / 1000;
    localparam int          RESTART_NS       = 200;
    localparam int          RESTART_CYCLES   = (RESTART_NS * CLK_MHZ + 999) / 1000;
    localparam int          SENSE_NS         = 80;
    localparam int          SENSE_CYCLES     = (SENSE_NS * CLK_MHZ + 999) / 1000;
    localparam int          SEQ_CNT_WIDTH    = 8;

    typedef enum logic [5:0] {
        ST_ACTIVE  = 6'h01,
        ST_ENTER   = 6'h02,
        ST_STOP    = 6'h04,
        ST_SLEEP   = 6'h08,
        ST_SENSE   = 6'h10,
        ST_RESTART = 6'h20
    } pmw_state_t;
endpackage

// File: logic/pmw_edge_detect.sv
// edge qualified wake detector for one external input
`timescale 1ns/1ps
module pmw_edge_detect (
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       pin_i,
    input  wire logic [1:0] edge_sel_i,
    output logic            level_o,
    output logic            event_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } pmw_ed_t;

    pmw_ed_t st_reg;
    pmw_ed_t st_next;
    logic    rise;
    logic    fall;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = pin_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.lvl = st_reg.s3;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rise    = st_next.lvl & ~st_reg.lvl;
    assign fall    = ~st_next.lvl & st_reg.lvl;
    assign level_o = st_reg.lvl;
    assign event_o = (rise & edge_sel_i[0]) | (fall & edge_sel_i[1]);
endmodule

// File: logic/pmw_core.sv
// power mode sequencer with wake source capture and cyclic wake / sense
`timescale 1ns/1ps
module pmw_core #(
    parameter int NUM_MON     = pmw_pkg::NUM_MON,
    parameter int NUM_GPIO    = pmw_pkg::NUM_GPIO,
    parameter int TIMER_WIDTH = pmw_pkg::TIMER_WIDTH
) (
    input  wire logic                                core_clk_i,
    input  wire logic                                rstn_i,
    // software side
    input  wire logic                                stop_req_i,
    input  wire logic                                sleep_req_i,
    input  wire logic                                cyc_wake_en_i,
    input  wire logic                                cyc_sense_en_i,
    input  wire logic                                sense_on_change_i,
    input  wire logic [NUM_MON-1:0]                  sense_mask_i,
    input  wire logic [NUM_MON-1:0]                  sense_target_i,
    input  wire logic [TIMER_WIDTH-1:0]              period_i,
    input  wire logic                                lin_wake_en_wr_i,
    input  wire logic                                lin_wake_en_i,
    input  wire logic                                mon_wake_en_wr_i,
    input  wire logic [NUM_MON-1:0]                  mon_wake_en_i,
    input  wire logic                                cyc_wake_en_wr_i,
    input  wire logic                                cyc_wake_src_en_i,
    input  wire logic [NUM_GPIO-1:0]                 gpio_wake_en_i,
    input  wire logic [2*NUM_MON-1:0]                mon_edge_sel_i,
    input  wire logic [2*NUM_GPIO-1:0]               gpio_edge_sel_i,
    input  wire logic [pmw_pkg::NUM_FLAGS-1:0]       flag_clr_i,
    input  wire logic                                ret_wr_i,
    input  wire logic [pmw_pkg::RET_WIDTH-1:0]       ret_data_i,
    // wake sources
    input  wire logic                                lin_wake_i,
    input  wire logic [NUM_MON-1:0]                  hv_monitor_input_i,
    input  wire logic [NUM_GPIO-1:0]                 gpio_i,
    // outputs
    output logic [pmw_pkg::NUM_FLAGS-1:0]            wake_flags_o,
    output logic [pmw_pkg::RET_WIDTH-1:0]            ret_data_o,
    output logic                                     lin_wake_en_o,
    output logic [NUM_MON-1:0]                       mon_wake_en_o,
    output logic                                     cyc_wake_src_en_o,
    output logic                                     core_supply_en_o,
    output logic                                     core_clk_en_o,
    output logic                                     modules_en_o,
    output logic                                     measurement_en_o,
    output logic                                     high_side_switch_o,
    output logic                                     core_rst_n_o,
    output logic [5:0]                               mode_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pmw_pkg::pmw_state_t                 state;
        logic                                to_sleep;
        logic                                cyc_wake;
        logic                                cyc_sense;
        logic                                armed_cyc;
        logic                                armed_sense;
        logic [TIMER_WIDTH-1:0]              timer;
        logic [pmw_pkg::SEQ_CNT_WIDTH-1:0]   seq_cnt;
        logic [NUM_MON-1:0]                  prev_sample;
        logic                                prev_valid;
        logic                                lin_en;
        logic [NUM_MON-1:0]                  mon_en;
        logic                                cyc_src_en;
        logic [pmw_pkg::NUM_FLAGS-1:0]       flags;
        logic [pmw_pkg::RET_WIDTH-1:0]       ret;
    } pmw_core_t;

    // last count of each timed phase
    localparam logic [pmw_pkg::SEQ_CNT_WIDTH-1:0] ENTRY_LAST =
        pmw_pkg::SEQ_CNT_WIDTH'(pmw_pkg::ENTRY_CYCLES - 1);
    localparam logic [pmw_pkg::SEQ_CNT_WIDTH-1:0] RESTART_LAST =
        pmw_pkg::SEQ_CNT_WIDTH'(pmw_pkg::RESTART_CYCLES - 1);
    localparam logic [pmw_pkg::SEQ_CNT_WIDTH-1:0] SENSE_LAST =
        pmw_pkg::SEQ_CNT_WIDTH'(pmw_pkg::SENSE_CYCLES - 1);

    pmw_core_t          st_reg;
    pmw_core_t          st_next;
    logic [NUM_MON-1:0] mon_lvl;
    logic [NUM_MON-1:0] mon_evt;
    logic [NUM_GPIO-1:0] gpio_evt;
    logic                lin_evt;
    logic                timer_evt;
    logic                sense_evt;
    logic                wake_any;
    logic [NUM_MON-1:0]  sense_now;
    logic [pmw_pkg::NUM_FLAGS-1:0] events;

    // ------------------------------------------------------------
    // input synchronisers and edge detectors
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MON; gi++) begin : g_mon
            pmw_edge_detect u_det (
                .core_clk_i (core_clk_i),
                .rstn_i     (rstn_i),
                .pin_i      (hv_monitor_input_i[gi]),
                .edge_sel_i (mon_edge_sel_i[2*gi +: 2]),
                .level_o    (mon_lvl[gi]),
                .event_o    (mon_evt[gi])
            );
        end
        for (gi = 0; gi < NUM_GPIO; gi++) begin : g_gpio
            pmw_edge_detect u_det (
                .core_clk_i (core_clk_i),
                .rstn_i     (rstn_i),
                .pin_i      (gpio_i[gi]),
                .edge_sel_i (gpio_edge_sel_i[2*gi +: 2]),
                .level_o    (),
                .event_o    (gpio_evt[gi])
            );
        end
    endgenerate

    // lin wake is a recessive to dominant edge, so dominant level alone never blocks entry
    pmw_edge_detect u_lin (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .pin_i      (lin_wake_i),
        .edge_sel_i (pmw_pkg::EDGE_RISE),
        .level_o    (),
        .event_o    (lin_evt)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_low_power(input pmw_pkg::pmw_state_t s);
        is_low_power = (s == pmw_pkg::ST_STOP) || (s == pmw_pkg::ST_SLEEP) ||
                       (s == pmw_pkg::ST_SENSE);
    endfunction

    function automatic pmw_pkg::pmw_state_t wake_state(input logic to_sleep);
        wake_state = to_sleep ? pmw_pkg::ST_RESTART : pmw_pkg::ST_ACTIVE;
    endfunction

    function automatic pmw_pkg::pmw_state_t rest_state(input logic to_sleep);
        rest_state = to_sleep ? pmw_pkg::ST_SLEEP : pmw_pkg::ST_STOP;
    endfunction

    // ------------------------------------------------------------
    // wake event sources
    // ------------------------------------------------------------
    assign timer_evt = is_low_power(st_reg.state) && st_reg.cyc_wake &&
                       st_reg.cyc_src_en && (st_reg.timer == '0);

    assign sense_now = mon_lvl & sense_mask_i;
    always_comb begin
        sense_evt = 1'b0;
        if (st_reg.state == pmw_pkg::ST_SENSE && st_reg.seq_cnt == SENSE_LAST) begin
            // change mode needs one earlier sample to compare
            if (sense_on_change_i) begin
                sense_evt = st_reg.prev_valid && (sense_now != st_reg.prev_sample);
            end else begin
                sense_evt = (sense_now == (sense_target_i & sense_mask_i));
            end
        end
    end

    // ------------------------------------------------------------
    // wake event collection
    // ------------------------------------------------------------
    always_comb begin
        events = '0;
        events[pmw_pkg::FLAG_LIN]   = lin_evt & st_reg.lin_en;
        events[pmw_pkg::FLAG_CYC]   = timer_evt;
        events[pmw_pkg::FLAG_SENSE] = sense_evt;
        events[pmw_pkg::NUM_FLAG_FIXED +: NUM_MON] = mon_evt & st_reg.mon_en;
        events[pmw_pkg::NUM_FLAG_FIXED + NUM_MON +: NUM_GPIO] = gpio_evt & gpio_wake_en_i;
    end

    // gpio wake is only a stop-mode source since their supply is off in sleep
    always_comb begin
        wake_any = (|events[pmw_pkg::NUM_FLAG_FIXED +: NUM_MON]) |
                   events[pmw_pkg::FLAG_LIN] | events[pmw_pkg::FLAG_CYC] |
                   events[pmw_pkg::FLAG_SENSE];
        if (!st_reg.to_sleep) begin
            wake_any = wake_any | (|events[pmw_pkg::NUM_FLAG_FIXED + NUM_MON +: NUM_GPIO]);
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // set wins over clear
        st_next.flags = (st_reg.flags & ~flag_clr_i) | events;

        if (lin_wake_en_wr_i) begin
            st_next.lin_en = lin_wake_en_i;
        end

        if (mon_wake_en_wr_i) begin
            st_next.mon_en = mon_wake_en_i;
        end

        if (cyc_wake_en_wr_i) begin
            st_next.cyc_src_en = cyc_wake_src_en_i;
        end

        if (ret_wr_i && st_reg.state == pmw_pkg::ST_ACTIVE) begin
            st_next.ret = ret_data_i;
        end

        // cyclic settings armed ahead of the mode command
        if (st_reg.state == pmw_pkg::ST_ACTIVE) begin
            st_next.armed_cyc   = cyc_wake_en_i;
            st_next.armed_sense = cyc_sense_en_i;
        end

        // period runs from the mode command, so a short one may expire during entry
        if (st_reg.timer != '0) begin
            st_next.timer = st_reg.timer - 1'b1;
        end

        case (st_reg.state)
            pmw_pkg::ST_ACTIVE: begin
                if (sleep_req_i || stop_req_i) begin
                    st_next.state     = pmw_pkg::ST_ENTER;
                    st_next.to_sleep  = sleep_req_i;
                    st_next.cyc_wake  = st_reg.armed_cyc;
                    st_next.cyc_sense = st_reg.armed_sense;
                    st_next.timer     = period_i;
                    st_next.seq_cnt   = '0;
                    st_next.prev_valid = 1'b0;
                end
            end

            pmw_pkg::ST_ENTER: begin
                st_next.seq_cnt = st_reg.seq_cnt + 1'b1;
                if (wake_any) begin
                    st_next.state   = wake_state(st_reg.to_sleep);
                    st_next.seq_cnt = '0;
                end else if (st_reg.seq_cnt == ENTRY_LAST) begin
                    st_next.state = rest_state(st_reg.to_sleep);
                end
            end

            pmw_pkg::ST_STOP,
            pmw_pkg::ST_SLEEP: begin
                if (wake_any) begin
                    st_next.state   = wake_state(st_reg.to_sleep);
                    st_next.seq_cnt = '0;
                end else if (st_reg.cyc_sense && st_reg.timer == '0) begin
                    st_next.state   = pmw_pkg::ST_SENSE;
                    st_next.seq_cnt = '0;
                end
            end

            pmw_pkg::ST_SENSE: begin
                st_next.seq_cnt = st_reg.seq_cnt + 1'b1;
                if (wake_any) begin
                    st_next.state   = wake_state(st_reg.to_sleep);
                    st_next.seq_cnt = '0;
                end else if (st_reg.seq_cnt == SENSE_LAST) begin
                    st_next.prev_sample = sense_now;
                    st_next.prev_valid  = 1'b1;
                    st_next.timer       = period_i;
                    st_next.state       = rest_state(st_reg.to_sleep);
                end
            end

            pmw_pkg::ST_RESTART: begin
                st_next.seq_cnt = st_reg.seq_cnt + 1'b1;
                if (st_reg.seq_cnt == RESTART_LAST) begin
                    st_next.state = pmw_pkg::ST_ACTIVE;
                end
            end

            default: begin
                st_next.state = pmw_pkg::ST_ACTIVE;
            end
        endcase

        // back in active the low power settings are dropped
        if (st_next.state == pmw_pkg::ST_ACTIVE && st_reg.state != pmw_pkg::ST_ACTIVE) begin
            st_next.to_sleep  = 1'b0;
            st_next.cyc_wake  = 1'b0;
            st_next.cyc_sense = 1'b0;
            st_next.timer     = '0;
        end
    end

    // settings come back at their defaults
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg            <= '0;
            st_reg.state      <= pmw_pkg::ST_ACTIVE;
            st_reg.lin_en     <= pmw_pkg::RST_LIN_WAKE_EN;
            st_reg.mon_en     <= {NUM_MON{pmw_pkg::RST_MON_WAKE_EN}};
            st_reg.cyc_src_en <= pmw_pkg::RST_CYC_WAKE_EN;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wake_flags_o       = st_reg.flags;
    assign ret_data_o         = st_reg.ret;
    assign lin_wake_en_o      = st_reg.lin_en;
    assign mon_wake_en_o      = st_reg.mon_en;
    assign cyc_wake_src_en_o  = st_reg.cyc_src_en;
    assign mode_o             = st_reg.state;

    assign modules_en_o       = (st_reg.state == pmw_pkg::ST_ACTIVE);
    assign measurement_en_o   = (st_reg.state == pmw_pkg::ST_ACTIVE);
    assign core_clk_en_o      = (st_reg.state == pmw_pkg::ST_ACTIVE);

    // stop keeps the core supplied, sleep cuts it
    assign core_supply_en_o   = !(st_reg.to_sleep && (st_reg.state == pmw_pkg::ST_SLEEP ||
                                 st_reg.state == pmw_pkg::ST_SENSE));
    assign core_rst_n_o       = (st_reg.state != pmw_pkg::ST_RESTART) &&
                                core_supply_en_o;
    assign high_side_switch_o = (st_reg.state == pmw_pkg::ST_SENSE);
endmodule

// File: verification/pmw_core_props.sv
// checker: mode, supply and wake flag relations at the controller ports
`timescale 1ns/1ps
module pmw_core_props #(
    parameter int NUM_MON = pmw_pkg::NUM_MON
) (
    input wire logic                          core_clk_i,
    input wire logic                          rstn_i,
    input wire logic                          sleep_req_i,
    input wire logic [pmw_pkg::NUM_FLAGS-1:0] flag_clr_i,
    input wire logic [pmw_pkg::NUM_FLAGS-1:0] wake_flags_o,
    input wire logic                          lin_wake_en_o,
    input wire logic [NUM_MON-1:0]            mon_wake_en_o,
    input wire logic                          cyc_wake_src_en_o,
    input wire logic                          core_supply_en_o,
    input wire logic                          core_clk_en_o,
    input wire logic                          modules_en_o,
    input wire logic                          measurement_en_o,
    input wire logic                          high_side_switch_o,
    input wire logic                          core_rst_n_o,
    input wire logic [5:0]                    mode_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_active_on;
        mode_o == 6'h01 |-> modules_en_o && core_clk_en_o && measurement_en_o && core_supply_en_o;
    endproperty
    a_active_on: assert property (p_active_on) else $error("active mode output off");
    property p_take;
        mode_o == 6'h01 && sleep_req_i |=> mode_o == 6'h02;
    endproperty
    a_take: assert property (p_take) else $error("sleep request not taken");
    property p_stop_pwr;
        mode_o == 6'h04 |-> core_supply_en_o && !core_clk_en_o;
    endproperty
    a_stop_pwr: assert property (p_stop_pwr) else $error("stop supply or clock wrong");
    property p_sleep_pwr;
        mode_o == 6'h08 |-> !core_supply_en_o && !core_rst_n_o;
    endproperty
    a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep supply not off");
    property p_sleep_exit;
        mode_o == 6'h08 ##1 !(mode_o inside {6'h08, 6'h10}) |-> mode_o == 6'h20;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit not restart");
    property p_restart;
        $rose(mode_o == 6'h20) |-> (!core_rst_n_o && mode_o == 6'h20) [*8];
    endproperty
    a_restart: assert property (p_restart) else $error("restart reset too short");
    property p_sticky;
        (~wake_flags_o & $past(wake_flags_o) & ~$past(flag_clr_i)) == '0;
    endproperty
    a_sticky: assert property (p_sticky) else $error("wake flag cleared by hardware");
    property p_defaults;
        $rose(rstn_i) |-> !lin_wake_en_o && (&mon_wake_en_o) && cyc_wake_src_en_o;
    endproperty
    a_defaults: assert property (p_defaults) else $error("wake enable defaults wrong");
    property p_hs_sense;
        high_side_switch_o |-> mode_o == 6'h10;
    endproperty
    a_hs_sense: assert property (p_hs_sense) else $error("high side on outside sense");
    property p_hs_hold;
        $rose(mode_o == 6'h10) |-> high_side_switch_o [*8];
    endproperty
    a_hs_hold: assert property (p_hs_hold) else $error("high side not on in sense");
    property p_stop_wake;
        $rose(wake_flags_o[3]) && mon_wake_en_o[0] && $past(mode_o) == 6'h04
            |-> ##[0:1] mode_o == 6'h01;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop not left on wake");
    property p_entry_wake;
        $rose(wake_flags_o[5]) && mon_wake_en_o[2] && $past(mode_o) == 6'h02
            |-> ##[0:2] (mode_o == 6'h01 || mode_o == 6'h20);
    endproperty
    a_entry_wake: assert property (p_entry_wake) else $error("wake lost in entry");
endmodule

// File: verification/pmw_wake_src_model.sv
// model of the external wake sources: lin bus, monitor pins and gpios
`timescale 1ns/1ps
module pmw_wake_src_model (
    input  wire logic                         core_clk_i,
    input  wire logic                         lin_dom_i,
    input  wire logic [pmw_pkg::NUM_MON-1:0]  mon_lvl_i,
    input  wire logic [pmw_pkg::NUM_GPIO-1:0] gpio_lvl_i,
    output logic                              lin_wake_o,
    output logic [pmw_pkg::NUM_MON-1:0]       hv_monitor_input_o,
    output logic [pmw_pkg::NUM_GPIO-1:0]      gpio_o
);
    // pins follow the bench just after a rising edge, clear of its falling-edge writes
    always @(posedge core_clk_i) begin
        lin_wake_o <= lin_dom_i;
        hv_monitor_input_o <= mon_lvl_i;
        gpio_o <= gpio_lvl_i;
    end
endmodule

// File: verification/power_mode_wake_control_test.sv
// testbench: mode sequences and wake sources of the power mode controller
`timescale 1ns/1ps
module power_mode_wake_control_test;
    logic        core_clk_i = 0, rstn_i = 0, stop_req_i = 0, sleep_req_i = 0;
    logic        cyc_wake_en_i = 0, cyc_sense_en_i = 0, sense_on_change_i = 0;
    logic [4:0]  sense_mask_i = 0, sense_target_i = 0, mon_wake_en_i = 0, mon_lvl = 0;
    logic [15:0] period_i = 16'h001E;
    logic        lin_wake_en_wr_i = 0, lin_wake_en_i = 0, mon_wake_en_wr_i = 0;
    logic        cyc_wake_en_wr_i = 0, cyc_wake_src_en_i = 0, ret_wr_i = 0, lin_dom = 0;
    logic [3:0]  gpio_wake_en_i = 0, gpio_lvl = 0;
    logic [9:0]  mon_edge_sel_i = 0;
    logic [7:0]  gpio_edge_sel_i = 0;
    logic [11:0] flag_clr_i = 0, wake_flags_o;
    logic [63:0] ret_data_i = 64'hA5A5_0F0F_1234_5678, ret_data_o;
    logic        lin_wake_i, lin_wake_en_o, cyc_wake_src_en_o, core_supply_en_o;
    logic        core_clk_en_o, modules_en_o, measurement_en_o, high_side_switch_o;
    logic        core_rst_n_o;
    logic [4:0]  hv_monitor_input_i, mon_wake_en_o;
    logic [3:0]  gpio_i;
    logic [5:0]  mode_o;
    int          n_mismatch = 0, samples_checked = 0, n;

    pmw_wake_src_model src (.core_clk_i(core_clk_i), .lin_dom_i(lin_dom), .mon_lvl_i(mon_lvl),
        .gpio_lvl_i(gpio_lvl), .lin_wake_o(lin_wake_i), .hv_monitor_input_o(hv_monitor_input_i),
        .gpio_o(gpio_i));
    pmw_core uut (.*);

    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    task automatic tick(input int c);
        repeat (c) @(negedge core_clk_i);
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_mode(input logic [5:0] m);
        for (int i = 0; i < 2000 && mode_o !== m; i++) tick(1);
        check(mode_o, m);
    endtask
    task automatic clr();
        flag_clr_i = 12'hFFF;
        tick(1);
        flag_clr_i = 0;
        tick(1);
    endtask
    // cyclic arming lands a cycle ahead of the mode command
    task automatic enter(input logic slp, input logic cyc, input logic sns);
        cyc_wake_en_i = cyc;
        cyc_sense_en_i = sns;
        tick(1);
        sleep_req_i = slp;
        stop_req_i = !slp;
        tick(1);
        sleep_req_i = 0;
        stop_req_i = 0;
    endtask
    task automatic give_verdict();
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        tick(5);
        rstn_i = 1;
        check(mode_o, 6'h01);
        check({lin_wake_en_o, mon_wake_en_o, cyc_wake_src_en_o}, 7'h3F);
        check({modules_en_o, measurement_en_o, core_clk_en_o}, 3'h7);
        // per input edge selection, captured while active
        mon_edge_sel_i = {4'h0, pmw_pkg::EDGE_BOTH, pmw_pkg::EDGE_FALL, pmw_pkg::EDGE_RISE};
        mon_lvl = 5'h07;
        tick(8);
        check(wake_flags_o[7:3], 5'h05);
        mon_lvl = 5'h00;
        tick(28);
        check(wake_flags_o[7:3], 5'h07);
        clr();
        check(wake_flags_o, 12'h000);
        lin_wake_en_wr_i = 1;
        lin_wake_en_i = 1;
        tick(1);
        lin_wake_en_wr_i = 0;
        ret_wr_i = 1;
        tick(1);
        ret_wr_i = 0;
        check(ret_data_o, 64'hA5A5_0F0F_1234_5678);
        // sleep with lin dominant and cyclic timer wake
        lin_dom = 1;
        tick(8);
        clr();
        enter(1, 1, 0);
        check(mode_o, 6'h02);
        wait_mode(6'h08);
        ret_data_i = 64'h0;
        ret_wr_i = 1;
        tick(1);
        ret_wr_i = 0;
        wait_mode(6'h20);
        check(wake_flags_o[pmw_pkg::FLAG_CYC], 1'h1);
        wait_mode(6'h01);
        check(ret_data_o, 64'hA5A5_0F0F_1234_5678);
        clr();
        // stop left by a monitor edge, then by a gpio edge
        enter(0, 0, 0);
        wait_mode(6'h04);
        check({core_supply_en_o, core_clk_en_o, modules_en_o}, 3'h4);
        mon_lvl = 5'h01;
        wait_mode(6'h01);
        check(wake_flags_o[3], 1'h1);
        gpio_wake_en_i = 4'h1;
        gpio_edge_sel_i = {6'h0, pmw_pkg::EDGE_RISE};
        clr();
        enter(0, 0, 0);
        wait_mode(6'h04);
        gpio_lvl = 4'h1;
        wait_mode(6'h01);
        check(wake_flags_o[8], 1'h1);
        gpio_lvl = 4'h0;
        tick(8);
        clr();
        // gpio does not end sleep, lin does
        enter(1, 0, 0);
        wait_mode(6'h08);
        lin_dom = 0;
        gpio_lvl = 4'h1;
        tick(30);
        check(mode_o, 6'h08);
        check(wake_flags_o[8], 1'h1);
        lin_dom = 1;
        wait_mode(6'h20);
        check(wake_flags_o[pmw_pkg::FLAG_LIN], 1'h1);
        wait_mode(6'h01);
        clr();
        // wake arriving in mid entry aborts it
        enter(1, 0, 0);
        mon_lvl = 5'h05;
        tick(6);
        check(mode_o, 6'h20);
        check(wake_flags_o[5], 1'h1);
        wait_mode(6'h01);
        clr();
        // cyclic sense, change case then match case
        sense_mask_i = 5'h08;
        sense_on_change_i = 1;
        enter(0, 0, 1);
        wait_mode(6'h10);
        for (n = 0; n < 100 && high_side_switch_o === 1'h1; n++) tick(1);
        check(n, pmw_pkg::SENSE_CYCLES);
        check(mode_o, 6'h04);
        mon_lvl = 5'h0D;
        wait_mode(6'h10);
        tick(22);
        check(mode_o, 6'h01);
        check(wake_flags_o[pmw_pkg::FLAG_SENSE], 1'h1);
        sense_on_change_i = 0;
        sense_target_i = 5'h08;
        enter(0, 0, 1);
        wait_mode(6'h10);
        tick(22);
        check(mode_o, 6'h01);
        // software writes of wake source enables
        mon_wake_en_wr_i = 1;
        mon_wake_en_i = 5'h1E;
        cyc_wake_en_wr_i = 1;
        tick(1);
        mon_wake_en_wr_i = 0;
        cyc_wake_en_wr_i = 0;
        check({mon_wake_en_o, cyc_wake_src_en_o, lin_wake_en_o}, 7'h79);
        give_verdict();
    end
endmodule

bind pmw_core pmw_core_props #(.NUM_MON(NUM_MON)) u_props (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .sleep_req_i(sleep_req_i), .flag_clr_i(flag_clr_i),
    .wake_flags_o(wake_flags_o), .lin_wake_en_o(lin_wake_en_o), .mon_wake_en_o(mon_wake_en_o),
    .cyc_wake_src_en_o(cyc_wake_src_en_o), .core_supply_en_o(core_supply_en_o),
    .core_clk_en_o(core_clk_en_o), .modules_en_o(modules_en_o),
    .measurement_en_o(measurement_en_o), .high_side_switch_o(high_side_switch_o),
    .core_rst_n_o(core_rst_n_o), .mode_o(mode_o));
